// >>> verilog/bcd_result_port.sv
// BCD result output port with request / data-valid handshake
`timescale 1ns/100ps
`include "bcd_port_map.svh"

module bcd_result_port import bcd_port_pkg::*; #(
	parameter int VAL_W = `BCD_VAL_W,
	parameter int MS_CYCLES = `BCD_MS_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Controller side inputs
	input wire logic requestN,
	input wire logic holdN,
	// Measurement source
	input wire logic measStrobe,
	input wire logic [VAL_W-1:0] measValue,
	// Port outputs; drive high means the open-collector lines are switched
	output bcd_out_t portOut
);

	localparam int MS_W = $clog2(MS_CYCLES);

	if (MS_CYCLES < 2) begin : gBadDiv
		$error("MS_CYCLES must be at least 2");
	end

	// Sixteen bits still fit five decimal digits; wider values would overflow them
	if (VAL_W < 1 || VAL_W > 16) begin : gBadVal
		$error("VAL_W must give a value that fits five decimal digits");
	end

	logic reqOn, holdOn, reqOnPrev_r, reqEdge, msTick, convBusy;
	bcd_word_t convBcd, fresh;
	port_state_t state_r, state_nxt;
	logic [MS_W-1:0] msCnt_r, msCnt_nxt;
	logic [6:0] tickCnt_r, tickCnt_nxt;
	bcd_word_t digits_r, digits_nxt;
	logic valid_r, valid_nxt, drive_r, drive_nxt;

	assign reqOn = !requestN;
	assign holdOn = !holdN;
	assign reqEdge = reqOn && !reqOnPrev_r;

	// ****************************************
	// Binary to BCD conversion of each measurement strobed while the converter is not busy
	// ****************************************
	bcd_digit_conv #(
		.VAL_W(VAL_W)
	) uConv (
		.core_clk(core_clk),
		.rstn(rstn),
		.start(measStrobe),
		.binIn(measValue),
		.busy(convBusy),
		.bcdOut(convBcd)
	);

	// Hold freezes the shown value; a changeover loads either the old or the new word whole
	assign fresh = holdOn ? digits_r : convBcd;

	// ****************************************
	// Millisecond enable and port sequencer
	// ****************************************
	assign msTick = (msCnt_r == MS_W'(MS_CYCLES - 1));

	always_comb begin
		state_nxt = state_r;
		tickCnt_nxt = tickCnt_r;
		digits_nxt = digits_r;
		valid_nxt = valid_r;
		drive_nxt = drive_r;
		msCnt_nxt = msTick ? '0 : msCnt_r + MS_W'(1);
		case (state_r)
			S_IDLE: begin
				// Nothing is shown until the controller asks
				if (reqEdge) begin
					state_nxt = S_SETUP;
					tickCnt_nxt = '0;
					msCnt_nxt = '0;
				end
			end
			S_SETUP: begin
				if (msTick) begin
					if (tickCnt_r == `BCD_SETUP_MS - 7'h1) begin
						state_nxt = S_VALID;
						tickCnt_nxt = '0;
						digits_nxt = convBcd;
						drive_nxt = 1'b1;
						valid_nxt = 1'b1;
					end else begin
						tickCnt_nxt = tickCnt_r + 7'h1;
					end
				end
			end
			S_VALID: begin
				if (msTick) begin
					tickCnt_nxt = tickCnt_r + 7'h1;
					if (tickCnt_r >= `BCD_VALID_MS - 7'h1 && !reqOn) begin
						state_nxt = S_RELEASE;
						tickCnt_nxt = '0;
						valid_nxt = 1'b0;
					end else if (tickCnt_r == `BCD_PERIOD_MS - 7'h1) begin
						// Valid drops for one ms so the word never changes under it
						state_nxt = S_CHG;
						valid_nxt = 1'b0;
						digits_nxt = fresh;
					end
				end
			end
			S_CHG: begin
				// The low tick belongs to the next period, so the count restarts at one
				if (msTick) begin
					state_nxt = S_VALID;
					tickCnt_nxt = 7'h1;
					valid_nxt = 1'b1;
				end
			end
			S_RELEASE: begin
				if (msTick) begin
					if (tickCnt_r == `BCD_RELEASE_MS - 7'h1) begin
						state_nxt = S_IDLE;
						drive_nxt = 1'b0;
						digits_nxt = '0;
					end else begin
						tickCnt_nxt = tickCnt_r + 7'h1;
					end
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_IDLE;
			msCnt_r <= '0;
			tickCnt_r <= '0;
			digits_r <= '0;
			valid_r <= 1'b0;
			drive_r <= 1'b0;
			reqOnPrev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			msCnt_r <= msCnt_nxt;
			tickCnt_r <= tickCnt_nxt;
			digits_r <= digits_nxt;
			valid_r <= valid_nxt;
			drive_r <= drive_nxt;
			reqOnPrev_r <= reqOn;
		end
	end

	assign portOut = '{digits: digits_r, valid: valid_r, drive: drive_r};

	// ****************************************
	// Assertions
	// ****************************************
	// One clock domain, so a single default clocking serves every property
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	req_start_a: assert property ((state_r == S_IDLE && !requestN && reqOnPrev_r == 1'b0)
		|=> state_r == S_SETUP)
		else $error("Low request did not start a read");
	idle_quiet_a: assert property ((state_r == S_IDLE || state_r == S_SETUP) |-> !valid_r)
		else $error("Data valid shown without a request");
	drive_only_a: assert property ((state_r == S_IDLE || state_r == S_SETUP) |-> !drive_r)
		else $error("Data lines switched before data valid");
	setup_end_a: assert property ((state_r == S_SETUP && msTick && tickCnt_r == `BCD_SETUP_MS - 7'h1)
		|=> valid_r && drive_r)
		else $error("Data valid not raised at end of setup");
	setup_len_a: assert property ((state_r == S_SETUP) |-> tickCnt_r < `BCD_SETUP_MS)
		else $error("Setup phase ran past its length");
	valid_end_a: assert property ((state_r == S_VALID && msTick && requestN
		&& tickCnt_r == `BCD_VALID_MS - 7'h1)
		|=> !valid_r && drive_r && state_r == S_RELEASE)
		else $error("Data valid not dropped after its window");
	release_end_a: assert property ((state_r == S_RELEASE && msTick
		&& tickCnt_r == `BCD_RELEASE_MS - 7'h1) |=> !drive_r ##1 !drive_r)
		else $error("Data lines not released after valid");

	// Levels that must hold in every phase, then the levels of the release phase
	valid_drive_a: assert property (valid_r |-> drive_r)
		else $error("Data valid shown with lines released");
	off_zero_a: assert property (!drive_r |-> digits_r == '0)
		else $error("Data left on released lines");
	release_state_a: assert property ((state_r == S_RELEASE) |-> drive_r && !valid_r)
		else $error("Release phase shows wrong levels");

	cont_refresh_a: assert property ((state_r == S_VALID && msTick && !requestN
		&& tickCnt_r == `BCD_PERIOD_MS - 7'h1)
		|=> !valid_r && drive_r && state_r == S_CHG)
		else $error("Continuous refresh missed");
	refresh_load_a: assert property ((state_r == S_VALID && msTick && !requestN && holdN
		&& tickCnt_r == `BCD_PERIOD_MS - 7'h1) |=> digits_r == $past(convBcd))
		else $error("Refresh did not load the newest value");
	chg_end_a: assert property ((state_r == S_CHG && msTick) |=> valid_r && state_r == S_VALID)
		else $error("Changeover longer than one tick");
	valid_len_a: assert property ((state_r == S_VALID) |-> tickCnt_r < `BCD_PERIOD_MS)
		else $error("Valid window ran past one period");
	chg_drive_a: assert property ((state_r == S_CHG) |-> drive_r && $stable(drive_r))
		else $error("Data lines dropped during changeover");
	hold_keep_a: assert property ((state_r == S_VALID && msTick && !requestN && !holdN
		&& tickCnt_r == `BCD_PERIOD_MS - 7'h1) |=> $stable(digits_r))
		else $error("Held value changed at changeover");
	data_stable_a: assert property ((valid_r && $past(valid_r)) |-> $stable(digits_r))
		else $error("Data changed while valid");
	bcd_legal_a: assert property (drive_r |-> digits_r[3:0] <= 4'h9 && digits_r[7:4] <= 4'h9
		&& digits_r[11:8] <= 4'h9 && digits_r[15:12] <= 4'h9 && digits_r[19:16] <= 4'h9)
		else $error("Shown digit is not decimal");

endmodule

// >>> verilog/bcd_port_map.svh
// Timing and format constants for the BCD result port
`ifndef BCD_PORT_MAP_SVH
`define BCD_PORT_MAP_SVH

// ****************************************
// Clock and millisecond divider
// ****************************************
`define BCD_CLK_HZ 50000000
`define BCD_MS_PER_S 1000
`define BCD_MS_CYCLES (`BCD_CLK_HZ / `BCD_MS_PER_S)

// ****************************************
// Port timing in milliseconds
// ****************************************
`define BCD_SETUP_MS 7'h1e
`define BCD_VALID_MS 7'h28
`define BCD_RELEASE_MS 7'h10
`define BCD_PERIOD_MS 7'h40
`define BCD_GAP_MS 7'h14

// ****************************************
// Data format
// ****************************************
`define BCD_DIGITS 5
`define BCD_DIGIT_W 4
`define BCD_VAL_W 16

`endif

// >>> verilog/bcd_port_pkg.sv
// Types shared by the BCD result port design
`include "bcd_port_map.svh"

package bcd_port_pkg;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETUP = 3'b001,
		S_VALID = 3'b010,
		S_CHG = 3'b011,
		S_RELEASE = 3'b100
	} port_state_t;

	typedef logic [`BCD_DIGITS*`BCD_DIGIT_W-1:0] bcd_word_t;

	typedef struct packed {
		bcd_word_t digits;
		logic valid;
		logic drive;
	} bcd_out_t;

endpackage

// >>> verilog/bcd_digit_conv.sv
// Sequential binary to BCD converter (shift and add three)
`timescale 1ns/100ps
`include "bcd_port_map.svh"

module bcd_digit_conv import bcd_port_pkg::*; #(
	parameter int VAL_W = `BCD_VAL_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Request
	input wire logic start,
	input wire logic [VAL_W-1:0] binIn,
	// Result
	output logic busy,
	output bcd_word_t bcdOut
);

	localparam int BCD_W = `BCD_DIGITS * `BCD_DIGIT_W;
	localparam int CNT_W = $clog2(VAL_W + 1);

	if (VAL_W < 1 || VAL_W > 16) begin : gBadWidth
		$error("VAL_W must give a value that fits five decimal digits");
	end

	logic [BCD_W-1:0] acc_r, acc_nxt, accAdj;
	logic [VAL_W-1:0] bin_r, bin_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	bcd_word_t bcdOut_r, bcdOut_nxt;

	// ****************************************
	// Per-digit correction before each shift
	// ****************************************
	for (genvar d = 0; d < `BCD_DIGITS; d++) begin : gAdj
		assign accAdj[d*4 +: 4] = (acc_r[d*4 +: 4] > 4'h4) ? acc_r[d*4 +: 4] + 4'h3 : acc_r[d*4 +: 4];
	end

	always_comb begin
		acc_nxt = acc_r;
		bin_nxt = bin_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		bcdOut_nxt = bcdOut_r;
		if (!busy_r) begin
			if (start) begin
				acc_nxt = '0;
				bin_nxt = binIn;
				cnt_nxt = CNT_W'(VAL_W);
				busy_nxt = 1'b1;
			end
		end else if (cnt_r == '0) begin
			bcdOut_nxt = acc_r;
			busy_nxt = 1'b0;
		end else begin
			acc_nxt = {accAdj[BCD_W-2:0], bin_r[VAL_W-1]};
			bin_nxt = bin_r << 1;
			cnt_nxt = cnt_r - CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc_r <= '0;
			bin_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			bcdOut_r <= '0;
		end else begin
			acc_r <= acc_nxt;
			bin_r <= bin_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			bcdOut_r <= bcdOut_nxt;
		end
	end

	assign busy = busy_r;
	assign bcdOut = bcdOut_r;

endmodule

// >>> sim/bcd_ctrl_model.sv
// Controller model that requests and samples BCD data
`timescale 1ns/100ps

module bcd_ctrl_model import bcd_port_pkg::*; #(
	parameter int GAP = 80
) (
	// Clock
	input wire logic core_clk,
	// Bench commands
	input wire logic go,
	input wire logic keep,
	// Port
	input wire bcd_out_t portOut,
	output logic requestN = 1'b1,
	output bcd_word_t seen,
	output logic ready
);
	int quiet = 0;
	logic vd = 1'b0;

	// ****
	// Request and sampling
	// ****
	always @(posedge core_clk) begin
		vd <= portOut.valid;
		if (portOut.valid && !vd)
			seen <= portOut.digits;
		quiet <= portOut.valid ? 0 : quiet + 1;
		if (go && ready)
			requestN <= 1'b0;
		else if (!keep && portOut.valid)
			requestN <= 1'b1;
	end
	// Counts from valid low, so the gap is never short
	assign ready = quiet >= GAP;
endmodule

// >>> sim/bcd_result_port_test.sv
// Self-checking bench for the BCD result port
`timescale 1ns/100ps

module bcd_result_port_test import bcd_port_pkg::*;;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic holdN = 1'b1;
	logic measStrobe = 1'b0;
	logic [15:0] measValue = 16'h0;
	logic go = 1'b0;
	logic keep = 1'b0;
	logic requestN, ready, lastV;
	bcd_word_t seen, lastD;
	bcd_out_t portOut;
	int errors = 0;
	int tests_run = 0;
	int n, m;
	logic [15:0] v, w;

	always #10 core_clk = ~core_clk;

	bcd_result_port #(.MS_CYCLES(4)) u_bcd_result_port (.core_clk(core_clk), .rstn(rstn),
		.requestN(requestN), .holdN(holdN), .measStrobe(measStrobe), .measValue(measValue),
		.portOut(portOut));
	bcd_ctrl_model u_bcd_ctrl_model (.core_clk(core_clk), .go(go), .keep(keep),
		.portOut(portOut), .requestN(requestN), .seen(seen), .ready(ready));

	// ****
	// Helpers
	// ****
	function automatic bcd_word_t toBcd(input int x);
		bcd_word_t r;
		r = '0;
		for (int i = 0; i < 5; i++) begin
			r[i*4 +: 4] = 4'(x % 10);
			x = x / 10;
		end
		return r;
	endfunction

	function automatic logic near(input int x, input int e);
		return (x >= e - 1) && (x <= e + 1);
	endfunction

	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic waitSig(input bit drv, input logic lvl, output int c);
		c = 0;
		while ((drv ? portOut.drive : portOut.valid) !== lvl && c < 2000) begin
			@(posedge core_clk);
			#1 c++;
		end
	endtask

	task automatic meas(input logic [15:0] x);
		@(posedge core_clk);
		measStrobe <= 1'b1;
		measValue <= x;
		@(posedge core_clk);
		measStrobe <= 1'b0;
		repeat (24) @(posedge core_clk);
	endtask

	task automatic ask();
		wait (ready === 1'b1);
		@(posedge core_clk);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		wait (requestN === 1'b0);
		#1;
	endtask

	task automatic conclude();
		$display("tests %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****
	// Monitors
	// ****
	always @(posedge core_clk) begin
		lastD <= portOut.digits;
		lastV <= portOut.valid;
		if (portOut.drive === 1'b1 && portOut.digits === '0)
			check("digits zero", 1'b1, 1'b0);
		if (portOut.valid === 1'b1 && lastV === 1'b1)
			check("stable", portOut.digits, lastD);
	end

	initial begin
		#400000;
		errors++;
		conclude();
	end

	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(32'h510c));
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (40) @(posedge core_clk);
		#1;
		check("idle drive", portOut.drive, 1'b0);
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 16'hffff : 16'($urandom_range(1, 65535));
			meas(v);
			ask();
			waitSig(0, 1'b1, n);
			check("setup", near(n, 122), 1'b1);
			check("digits", portOut.digits, toBcd(v));
			waitSig(0, 1'b0, n);
			check("valid width", near(n, 160), 1'b1);
			check("sampled", seen, toBcd(v));
			waitSig(1, 1'b0, m);
			check("release", near(m, 64), 1'b1);
			check("digits off", portOut.digits, '0);
			$display("single %0d end", k);
		end
		// Held request, then a hold across one refresh
		w = 16'($urandom_range(1, 65535));
		meas(16'h0001);
		keep <= 1'b1;
		ask();
		waitSig(0, 1'b1, n);
		meas(w);
		waitSig(0, 1'b0, n);
		waitSig(0, 1'b1, m);
		check("period", near(26 + n, 256), 1'b1);
		check("chg gap", near(m, 4), 1'b1);
		check("refresh", portOut.digits, toBcd(w));
		@(posedge core_clk);
		holdN <= 1'b0;
		meas(16'($urandom_range(1, 65535)));
		waitSig(0, 1'b0, n);
		waitSig(0, 1'b1, n);
		check("hold", portOut.digits, toBcd(w));
		@(posedge core_clk);
		holdN <= 1'b1;
		keep <= 1'b0;
		waitSig(1, 1'b0, n);
		check("cont off", portOut.digits, '0);
		$display("continuous end");
		conclude();
	end
endmodule
